// >>> hdl/siop_pkg.sv
// Package with encodings and constants for the store, indirect and misc op unit.
package siop_pkg;
	localparam int SIOP_DATA_W = 8;
	localparam int SIOP_FADDR_W = 7;
	localparam int SIOP_PTR_W = 16;
	localparam int SIOP_OFS_W = 6;
	localparam logic [SIOP_PTR_W-1:0] SIOP_PTR_RST = 16'h0000;
	localparam logic [SIOP_PTR_W-1:0] SIOP_PTR_ONE = 16'h0001;
	localparam logic [SIOP_DATA_W-1:0] SIOP_OPT_RST = 8'hFF;
	localparam logic [SIOP_FADDR_W-1:0] SIOP_WIN0_ADDR = 7'h00;
	localparam logic [SIOP_FADDR_W-1:0] SIOP_WIN1_ADDR = 7'h01;
	localparam logic [1:0] SIOP_UPD_PREINC = 2'h0;
	localparam logic [1:0] SIOP_UPD_PREDEC = 2'h1;
	localparam logic [1:0] SIOP_UPD_POSTINC = 2'h2;
	localparam logic [1:0] SIOP_UPD_POSTDEC = 2'h3;
	localparam logic [7:0] SIOP_RST_PULSE_CYC = 8'h04;
	typedef enum logic [2:0] {
		SIOP_OP_NOP = 3'h0,
		SIOP_OP_STORE_DIRECT = 3'h1,
		SIOP_OP_STORE_IND_UPD = 3'h2,
		SIOP_OP_STORE_IND_OFS = 3'h3,
		SIOP_OP_OPTION = 3'h4,
		SIOP_OP_RESET = 3'h5
	} siop_op_t;
	typedef enum logic [1:0] {
		SIOP_ST_RUN = 2'h0,
		SIOP_ST_RESET = 2'h1
	} siop_state_t;
endpackage

// >>> hdl/siop_ptr_reg.sv
// One file pointer register with modular step and offset address forming.
`timescale 1ns/1ns
`default_nettype none
module siop_ptr_reg
	import siop_pkg::*;
#(
	parameter int PTR_W = SIOP_PTR_W
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Control.
	input wire logic upd_en,
	input wire logic [1:0] upd_code,
	input wire logic [SIOP_OFS_W-1:0] offset,
	// Results.
	output logic [PTR_W-1:0] eff_addr,
	output logic [PTR_W-1:0] ptr_val
);
	logic [PTR_W-1:0] ptr_q;
	logic [PTR_W-1:0] ptr_d;
	logic [PTR_W-1:0] step;
	logic [PTR_W-1:0] ofs_ext;

	always_comb begin
		ofs_ext = {{(PTR_W-SIOP_OFS_W){offset[SIOP_OFS_W-1]}}, offset};
		// Both codes with low bit set step down; arithmetic wraps mod 2^16.
		if (upd_code[0]) begin
			step = ptr_q - SIOP_PTR_ONE; // RULE5
		end else begin
			step = ptr_q + SIOP_PTR_ONE; // RULE5
		end
		ptr_d = ptr_q;
		if (upd_en) begin
			ptr_d = step; // RULE4
		end
		eff_addr = ptr_q + ofs_ext; // RULE3
		if (upd_en) begin
			if (upd_code[1]) begin
				eff_addr = ptr_q;
			end else begin
				eff_addr = step; // RULE4
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ptr_q <= SIOP_PTR_RST;
		end else begin
			ptr_q <= ptr_d;
		end
	end

	assign ptr_val = ptr_q;
endmodule
`default_nettype wire

// >>> hdl/siop_core.sv
// Execution unit for accumulator stores, indirect stores, option load, reset.
// Summary of operation
// (RULE1) Direct store copies accumulator to file register 0..127; no flags.
// (RULE2) Indirect store writes accumulator via pointer 0 or 1; no flags.
// (RULE3) Offset mode addresses pointer plus signed -32..31; pointer kept.
// (RULE4) Code 00 preinc, 01 predec, 10 postinc, 11 postdec; result kept.
// (RULE5) Pointers are 16 bits and wrap at both ends.
// (RULE6) Window registers have no storage; accesses go to pointer address.
// (RULE7) Pointer stepping never alters any status flag.
// (RULE8) Option load copies accumulator to option register; no flags.
// (RULE9) Software reset resets the device and clears the reset flag low.
// (RULE10) All ops except reset finish in one instruction cycle.
`timescale 1ns/1ns
`default_nettype none
module siop_core
	import siop_pkg::*;
#(
	parameter logic [7:0] RST_PULSE_CYC = SIOP_RST_PULSE_CYC
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Instruction issue from the decode stage.
	input wire logic op_valid,
	input wire logic [2:0] op_code,
	input wire logic [SIOP_FADDR_W-1:0] file_addr,
	input wire logic file_pointer_sel,
	input wire logic [1:0] pointer_update_code,
	input wire logic [SIOP_OFS_W-1:0] ptr_offset,
	input wire logic [SIOP_DATA_W-1:0] acc,
	// Reset-cause flag set from firmware.
	input wire logic sw_reset_flag_set,
	// Data memory write port.
	output logic mem_we,
	output logic [SIOP_PTR_W-1:0] mem_addr,
	output logic [SIOP_DATA_W-1:0] mem_wdata,
	// Configuration and power control state; op done and status write strobes.
	output logic [SIOP_DATA_W-1:0] option_reg,
	output logic sw_reset_flag_low,
	output logic dev_reset_req,
	output logic op_done,
	output logic status_we,
	// Pointer values.
	output logic [SIOP_PTR_W-1:0] ptr0,
	output logic [SIOP_PTR_W-1:0] ptr1
);
	////////////////////////////////////////////////////////////////////////
	// Instruction decode and the two pointer registers.
	siop_state_t st_q;
	siop_state_t st_d;
	logic run;
	logic take;
	logic is_dir;
	logic is_upd;
	logic is_ind;
	logic is_opt;
	logic is_rst;
	logic is_other;
	logic [1:0] upd_en;
	logic [SIOP_PTR_W-1:0] eff [2];
	logic [SIOP_PTR_W-1:0] pval [2];
	logic [SIOP_PTR_W-1:0] ind_addr;

	always_comb begin
		// Ops that arrive during a reset pulse are dropped entirely.
		run = st_q == SIOP_ST_RUN;
		take = op_valid && run;
		is_dir = take && op_code == SIOP_OP_STORE_DIRECT;
		is_upd = take && op_code == SIOP_OP_STORE_IND_UPD;
		is_ind = is_upd || (take && op_code == SIOP_OP_STORE_IND_OFS);
		is_opt = take && op_code == SIOP_OP_OPTION;
		is_rst = take && op_code == SIOP_OP_RESET;
		is_other = take && !(is_dir || is_ind || is_opt || is_rst);
		// Only the update form steps a pointer; the offset form leaves it.
		upd_en[0] = is_upd && !file_pointer_sel; // RULE4
		upd_en[1] = is_upd && file_pointer_sel; // RULE4
		ind_addr = eff[file_pointer_sel]; // RULE2
	end

	// Each pointer forms its own effective address; the select picks one.
	for (genvar g = 0; g < 2; g++) begin : g_ptr
		siop_ptr_reg #(.PTR_W(SIOP_PTR_W)) u_ptr (
			.clk(clk),
			.nrst(nrst),
			.upd_en(upd_en[g]),
			.upd_code(pointer_update_code),
			.offset(ptr_offset),
			.eff_addr(eff[g]),
			.ptr_val(pval[g])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Reset pulse counter and registered results.
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic mem_we_q;
	logic mem_we_d;
	logic [SIOP_PTR_W-1:0] mem_addr_q;
	logic [SIOP_PTR_W-1:0] mem_addr_d;
	logic [SIOP_DATA_W-1:0] mem_wdata_q;
	logic [SIOP_DATA_W-1:0] mem_wdata_d;
	logic [SIOP_DATA_W-1:0] opt_q;
	logic [SIOP_DATA_W-1:0] opt_d;
	logic flag_q;
	logic flag_d;
	logic rst_req_q;
	logic rst_req_d;
	logic done_q;
	logic done_d;
	logic status_we_q;
	logic status_we_d;

	// Next values: one result per taken op, or one tick of the reset pulse.
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		mem_we_d = 1'b0;
		mem_addr_d = mem_addr_q;
		mem_wdata_d = mem_wdata_q;
		opt_d = opt_q;
		flag_d = flag_q;
		rst_req_d = 1'b0;
		done_d = 1'b0;
		status_we_d = 1'b0; // RULE7
		// Firmware may set the flag again; a reset op below still clears it.
		if (sw_reset_flag_set) begin
			flag_d = 1'b1;
		end
		case (st_q)
		SIOP_ST_RUN: begin
			if (is_dir) begin
				mem_we_d = 1'b1; // RULE1
				mem_wdata_d = acc;
				done_d = 1'b1; // RULE10
				// Direct access to a window slot is redirected to its pointer.
				if (file_addr == SIOP_WIN0_ADDR) begin
					mem_addr_d = pval[0]; // RULE6
				end else if (file_addr == SIOP_WIN1_ADDR) begin
					mem_addr_d = pval[1]; // RULE6
				end else begin
					// Other addresses are zero-extended.
					mem_addr_d = {{(SIOP_PTR_W-SIOP_FADDR_W){1'b0}},
						file_addr}; // RULE1
				end
			end else if (is_ind) begin
				mem_we_d = 1'b1; // RULE2
				mem_wdata_d = acc;
				// Pre modes use the stepped pointer, post modes the old one.
				mem_addr_d = ind_addr; // RULE3
				done_d = 1'b1; // RULE10
			end else if (is_opt) begin
				// The option register keeps this value until the next load.
				opt_d = acc; // RULE8
				done_d = 1'b1; // RULE10
			end else if (is_rst) begin
				// Clearing the flag wins over a firmware set in the same cycle.
				flag_d = 1'b0; // RULE9
				rst_req_d = 1'b1; // RULE9
				cnt_d = RST_PULSE_CYC - 8'h01;
				st_d = SIOP_ST_RESET;
			end else if (is_other) begin
				done_d = 1'b1; // RULE10
			end
		end
		SIOP_ST_RESET: begin
			// Hold the request until the counter has run down to zero.
			rst_req_d = 1'b1; // RULE9
			if (cnt_q == 8'h00) begin
				rst_req_d = 1'b0;
				st_d = SIOP_ST_RUN;
			end else begin
				cnt_d = cnt_q - 8'h01;
			end
		end
		default: begin
			st_d = SIOP_ST_RUN;
		end
		endcase
	end

	// Registers only; every decision is made in the process above.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= SIOP_ST_RUN;
			cnt_q <= 8'h00;
			mem_we_q <= 1'b0;
			mem_addr_q <= SIOP_PTR_RST;
			mem_wdata_q <= '0;
			opt_q <= SIOP_OPT_RST;
			flag_q <= 1'b1;
			rst_req_q <= 1'b0;
			done_q <= 1'b0;
			status_we_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			mem_we_q <= mem_we_d;
			mem_addr_q <= mem_addr_d;
			mem_wdata_q <= mem_wdata_d;
			opt_q <= opt_d;
			flag_q <= flag_d;
			rst_req_q <= rst_req_d;
			done_q <= done_d;
			status_we_q <= status_we_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs come straight from the result registers.
	// No op in this group writes status; stepping a pointer leaves flags.
	assign status_we = status_we_q;
	assign mem_we = mem_we_q;
	assign mem_addr = mem_addr_q;
	assign mem_wdata = mem_wdata_q;
	assign option_reg = opt_q;
	assign sw_reset_flag_low = flag_q;
	assign dev_reset_req = rst_req_q;
	assign op_done = done_q;
	// Pointer values come from the registers inside each pointer module.
	assign ptr0 = pval[0];
	assign ptr1 = pval[1];
endmodule
`default_nettype wire

// >>> test/siop_core_assertions.sv
// Concurrent checks on the store, indirect and misc op unit.
`timescale 1ns/1ns
`default_nettype none
module siop_core_assertions
	import siop_pkg::*;
#(
	parameter logic [7:0] RST_PULSE_CYC = SIOP_RST_PULSE_CYC
) (
	// Clock, reset and issue.
	input wire logic clk,
	input wire logic nrst,
	input wire logic op_valid,
	input wire logic [2:0] op_code,
	input wire logic [6:0] file_addr,
	input wire logic file_pointer_sel,
	input wire logic [1:0] pointer_update_code,
	input wire logic [5:0] ptr_offset,
	input wire logic [7:0] acc,
	// Results.
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic [7:0] option_reg,
	input wire logic sw_reset_flag_low,
	input wire logic dev_reset_req,
	input wire logic op_done,
	input wire logic status_we,
	input wire logic [15:0] ptr0,
	input wire logic [15:0] ptr1
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic go;
	logic [15:0] sp, nx, ea;
	logic [7:0] hi_q;
	assign go = op_valid && !dev_reset_req;
	assign sp = file_pointer_sel ? ptr1 : ptr0;
	assign nx = sp + (pointer_update_code[0] ? 16'hFFFF : 16'h0001);
	assign ea = sp + {{10{ptr_offset[5]}}, ptr_offset};
	always_ff @(posedge clk or negedge nrst)
		if (!nrst) hi_q <= 8'h00;
		else hi_q <= dev_reset_req ? hi_q + 8'h01 : 8'h00;
	stat_we_a: assert property (!status_we)
		else $error("status write seen");
	dir_st_a: assert property (go && op_code == 3'h1 &&
		file_addr > 7'h01 |=> mem_we &&
		mem_addr == {9'h000, $past(file_addr)} &&
		mem_wdata == $past(acc)) else $error("direct store");
	win_store_a: assert property (go && op_code == 3'h1 &&
		file_addr < 7'h02 |=> mem_we && mem_addr ==
		($past(file_addr[0]) ? $past(ptr1) : $past(ptr0)))
		else $error("window store");
	ptr_upd_a: assert property (go && op_code == 3'h2 |=>
		mem_we && mem_wdata == $past(acc) &&
		($past(file_pointer_sel) ? ptr1 : ptr0) == $past(nx) &&
		($past(file_pointer_sel) ? $stable(ptr0) : $stable(ptr1)) &&
		mem_addr == ($past(pointer_update_code[1]) ?
		$past(sp) : $past(nx))) else $error("pointer update");
	ofs_store_a: assert property (go && op_code == 3'h3 |=>
		mem_we && mem_addr == $past(ea) && mem_wdata == $past(acc) &&
		$stable(ptr0) && $stable(ptr1)) else $error("offset store");
	opt_load_a: assert property (go && op_code == 3'h4 |=>
		option_reg == $past(acc) && !mem_we) else $error("option load");
	soft_rst_a: assert property (go && op_code == 3'h5 |=>
		dev_reset_req && !sw_reset_flag_low) else $error("soft reset");
	rst_len_a: assert property ($fell(dev_reset_req) |->
		hi_q == RST_PULSE_CYC) else $error("reset pulse length");
	op_done_a: assert property (go && op_code != 3'h5 |=> op_done)
		else $error("op not done");
	op_drop_a: assert property (op_valid && dev_reset_req |=>
		!mem_we && !op_done && $stable(ptr0) && $stable(ptr1))
		else $error("op taken in reset pulse");
	cover property (go && op_code == 3'h2);
	cover property (go && op_code == 3'h3);
	cover property (go && op_code == 3'h1 && file_addr < 7'h02);
	cover property ($fell(dev_reset_req));
endmodule
bind siop_core siop_core_assertions #(.RST_PULSE_CYC(RST_PULSE_CYC)) chk_i (.*);
`default_nettype wire

// >>> test/siop_core_test.sv
// Self-checking bench for the store, indirect and misc op unit.
`timescale 1ns/1ns
`default_nettype none
`define chk(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
	$display("mismatch %0t %h %h", $time, a, b); end end
module siop_core_test
	import siop_pkg::*;
();
	typedef struct packed {logic [2:0] o; logic [6:0] f; logic s;
		logic [1:0] c; logic [5:0] k; logic [7:0] a; logic [15:0] ea, ep;
	} siop_row_t;
	logic clk = 1'b0, nrst = 1'b0, ov = 1'b0, sel = 1'b0, fs = 1'b0;
	logic [2:0] op = 3'h0;
	logic [6:0] fa = 7'h00;
	logic [1:0] code = 2'h0;
	logic [5:0] ofs = 6'h00;
	logic [7:0] acc = 8'h00, wd, opt;
	logic [15:0] addr, p0, p1;
	logic we, flg, rq, done, swe;
	int errors = 0, tests_run = 0, i;
	siop_row_t rows [10] = '{
		'{3'h2, 7'h00, 1'b0, 2'h0, 6'h00, 8'h11, 16'h0001, 16'h0001},
		'{3'h2, 7'h00, 1'b0, 2'h1, 6'h00, 8'h22, 16'h0000, 16'h0000},
		'{3'h2, 7'h00, 1'b0, 2'h3, 6'h00, 8'h33, 16'h0000, 16'hFFFF},
		'{3'h2, 7'h00, 1'b0, 2'h2, 6'h00, 8'h44, 16'hFFFF, 16'h0000},
		'{3'h2, 7'h00, 1'b1, 2'h1, 6'h00, 8'h55, 16'hFFFF, 16'hFFFF},
		'{3'h3, 7'h00, 1'b1, 2'h0, 6'h20, 8'h66, 16'hFFDF, 16'hFFFF},
		'{3'h3, 7'h00, 1'b1, 2'h0, 6'h1F, 8'h77, 16'h001E, 16'hFFFF},
		'{3'h1, 7'h7F, 1'b1, 2'h0, 6'h00, 8'h88, 16'h007F, 16'hFFFF},
		'{3'h1, 7'h01, 1'b1, 2'h0, 6'h00, 8'h99, 16'hFFFF, 16'hFFFF},
		'{3'h1, 7'h00, 1'b0, 2'h0, 6'h00, 8'hAA, 16'h0000, 16'h0000}};
	siop_core #(.RST_PULSE_CYC(8'h04)) uut (.clk(clk), .nrst(nrst),
		.op_valid(ov), .op_code(op), .file_addr(fa), .file_pointer_sel(sel),
		.pointer_update_code(code), .ptr_offset(ofs), .acc(acc),
		.sw_reset_flag_set(fs), .mem_we(we), .mem_addr(addr),
		.mem_wdata(wd), .option_reg(opt), .sw_reset_flag_low(flg),
		.dev_reset_req(rq), .op_done(done), .status_we(swe), .ptr0(p0),
		.ptr1(p1));
	always #10 clk = ~clk;
	task automatic complete_run();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#5000;
		errors++;
		complete_run();
	end
	initial begin
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		`chk({opt, flg, p0, p1, we}, {8'hFF, 1'b1, 33'h0})
		$display("reset values done");
		for (i = 0; i < 10; i++) begin
			{op, fa, sel, code, ofs, acc} = rows[i][58:32];
			ov = 1'b1;
			@(negedge clk);
			`chk({we, done, swe}, 3'b110)
			`chk(wd, rows[i].a)
			`chk(addr, rows[i].ea)
			`chk(sel ? p1 : p0, rows[i].ep)
		end
		$display("store rows done");
		op = 3'h4;
		acc = 8'hA5;
		@(negedge clk);
		`chk({opt, we, done}, {8'hA5, 2'b01})
		op = 3'h0;
		@(negedge clk);
		`chk({we, done}, 2'b01)
		op = 3'h5;
		fs = 1'b1;
		@(negedge clk);
		fs = 1'b0;
		`chk({rq, flg}, 2'b10)
		op = 3'h2;
		repeat (3) begin
			@(negedge clk);
			`chk({rq, we, done, p0}, {3'b100, 16'h0000})
		end
		ov = 1'b0;
		@(negedge clk);
		`chk({rq, flg}, 2'b00)
		fs = 1'b1;
		@(negedge clk);
		fs = 1'b0;
		`chk(flg, 1'b1)
		$display("option and reset done");
		nrst = 1'b0;
		@(negedge clk);
		`chk({opt, flg, p1, rq, we}, {8'hFF, 1'b1, 18'h0})
		nrst = 1'b1;
		{op, sel, code} = {3'h2, 1'b1, 2'h0};
		ov = 1'b1;
		@(negedge clk);
		ov = 1'b0;
		`chk({we, addr, p1}, {1'b1, 32'h00010001})
		$display("mid-run reset done");
		complete_run();
	end
endmodule
`default_nettype wire
